// ### lrft_afe_model.sv
`timescale 1ns/1ps
module lrft_afe_model (
    // control from block
    input wire logic pclk,
    input wire logic presetn,
    input wire logic afe_start,
    input wire logic [3:0] afe_range,
    // scene set by bench
    input wire logic [19:0] light,
    input wire logic [3:0] sat_range,
    // sample to block, start count to bench
    output logic [19:0] adc_code,
    output logic adc_ovf,
    output int starts_q
);
    // a bright flash saturates every range below sat_range
    assign adc_ovf = afe_range < sat_range;
    assign adc_code = light;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            starts_q <= 0;
        end else if (afe_start) begin
            starts_q <= starts_q + 1;
        end
    end
endmodule // lrft_afe_model

// ### lrft_checker.sv
`timescale 1ns/1ps
module lrft_checker (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // front end and interrupt
    input wire logic afe_start,
    input wire logic [3:0] afe_range,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("no answer after setup");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready longer than one cycle");
    property p_ready_cause;
        pready |-> $past(psel) && penable;
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without a request");
    property p_err_with_ready;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("error outside an answer");
    property p_idle_data;
        !pready |-> prdata == 32'h0;
    endproperty
    a_idle_data: assert property (p_idle_data)
        else $error("read data outside an answer");
    property p_range_legal;
        afe_range <= 4'h8;
    endproperty
    a_range_legal: assert property (p_range_legal)
        else $error("range beyond maximum");
    // even the shortest period spans hundreds of cycles
    property p_start_spacing;
        afe_start |=> !afe_start [*8];
    endproperty
    a_start_spacing: assert property (p_start_spacing)
        else $error("conversions started too close");
    property p_irq_fall;
        $fell(irq) |-> $past(pready) || $past(pready, 2) || $past(pready, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without an access");

    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_start: cover property (afe_start);
endmodule // lrft_checker

bind lrft_top lrft_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .afe_start(afe_start), .afe_range(afe_range),
    .irq(irq));

// ### lrft_pkg.sv
package lrft_pkg;
    // clock rate
    localparam int unsigned CLK_MHZ = 200;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_THR_HI = 8'h04;
    localparam logic [7:0] OFS_THR_LO = 8'h08;
    localparam logic [7:0] OFS_RES_UP = 8'h0C;
    localparam logic [7:0] OFS_RES_LO = 8'h10;
    localparam logic [7:0] OFS_LINEAR = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // control field positions
    localparam int CT_LSB = 0;
    localparam int RG_LSB = 4;
    localparam int FC_LSB = 8;
    localparam int MD_LSB = 12;
    // field values
    localparam logic [3:0] CT_MAX = 4'hB;
    localparam logic [3:0] RG_MAX = 4'h8;
    localparam logic [3:0] RG_AUTO = 4'hC;
    localparam logic [1:0] MD_STANDBY = 2'h0;
    localparam logic [1:0] MD_ONESHOT = 2'h1;
    localparam logic [1:0] MD_CONT = 2'h2;
    // reset values
    localparam logic [3:0] CT_RST = 4'h8;
    localparam logic [3:0] RG_RST = 4'hC;
    localparam logic [1:0] FC_RST = 2'h0;
    // significand layout
    localparam int SIG_W = 20;
    localparam int UP_W = 12;
    localparam int LO_W = 8;
    localparam int LIN_W = 28;
    localparam int THR_W = 36;
    localparam logic [5:0] THR_PAD = 6'h08;
    localparam int MIN_BITS = 9;
    // auto range decision points on the significand
    localparam logic [19:0] SIG_HIGH_SIDE = 20'hC0000;
    localparam logic [19:0] SIG_LOW_SIDE = 20'h10000;
    localparam logic [19:0] SIG_FULL = 20'hFFFFF;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_HI = 1;
    localparam int IRQ_LO = 2;
    localparam int IRQ_W = 3;
    // conversion period per code, in microseconds
    localparam int unsigned CONV_US [12] = '{
        600, 1000, 1800, 3400, 6500, 12700,
        25000, 50000, 100000, 200000, 400000, 800000};

    typedef enum logic {LRFT_IDLE, LRFT_CONV} lrft_state_t;

    typedef struct packed {
        logic [3:0] exponent;
        logic [19:0] result_significand;
    } lrft_result_t;

    typedef struct packed {
        logic [3:0] exponent;
        logic [11:0] significand;
    } lrft_limit_t;
endpackage

// ### lrft_top.sv
`timescale 1ns/1ps
module lrft_top #(
    parameter int unsigned CYC_PER_US = lrft_pkg::CLK_MHZ
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end
    input wire logic [19:0] adc_code,
    input wire logic adc_ovf,
    output logic afe_start,
    output logic [3:0] afe_range,
    // interrupt
    output logic irq
);
    if (CYC_PER_US < 1 || CYC_PER_US > 5000) begin : g_chk
        $error("CYC_PER_US out of range");
    end

    // register state
    logic [3:0] ct_q;
    logic [3:0] rg_q;
    logic [1:0] fc_q;
    logic [1:0] md_q;
    lrft_pkg::lrft_limit_t thr_hi_q;
    lrft_pkg::lrft_limit_t thr_lo_q;
    lrft_pkg::lrft_result_t res_q;
    logic [27:0] lin_q;
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic [2:0] mask_q;
    logic flag_hi_q;
    logic flag_lo_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    // conversion state
    lrft_pkg::lrft_state_t st_q;
    logic [31:0] cnt_q;
    logic [3:0] range_q;
    logic [3:0] hi_cnt_q;
    logic [3:0] lo_cnt_q;
    logic start_q;

    // apb decode
    wire setup = psel & ~penable;
    wire acc_done = psel & penable & pready_q;
    wire wr_en = acc_done & pwrite;
    wire rd_en = acc_done & ~pwrite;
    wire a_ctrl = paddr == lrft_pkg::OFS_CTRL;
    wire a_thi = paddr == lrft_pkg::OFS_THR_HI;
    wire a_tlo = paddr == lrft_pkg::OFS_THR_LO;
    wire a_rup = paddr == lrft_pkg::OFS_RES_UP;
    wire a_rlo = paddr == lrft_pkg::OFS_RES_LO;
    wire a_lin = paddr == lrft_pkg::OFS_LINEAR;
    wire a_ist = paddr == lrft_pkg::OFS_IRQ_STAT;
    wire a_msk = paddr == lrft_pkg::OFS_IRQ_MASK;
    wire a_sts = paddr == lrft_pkg::OFS_STATUS;
    wire a_hit = a_ctrl | a_thi | a_tlo | a_rup | a_rlo | a_lin | a_ist
        | a_msk | a_sts;

    // control write fields; illegal count and range codes leave the field unchanged, mode is written as given
    wire [3:0] w_ct = pwdata[lrft_pkg::CT_LSB +: 4];
    wire [3:0] w_rg = pwdata[lrft_pkg::RG_LSB +: 4];
    wire ct_ok = w_ct <= lrft_pkg::CT_MAX;
    wire rg_ok = (w_rg <= lrft_pkg::RG_MAX) | (w_rg == lrft_pkg::RG_AUTO);
    wire auto_rng = rg_q == lrft_pkg::RG_AUTO;

    // conversion period in cycles for the selected code
    wire [31:0] conv_cyc = 32'(lrft_pkg::CONV_US[ct_q]) * 32'(CYC_PER_US);

    // sample path: overflow at a fixed range saturates the significand
    wire [19:0] raw_sig = adc_ovf ? lrft_pkg::SIG_FULL : adc_code;
    wire [19:0] sig_now;
    // low bits beyond the effective resolution read as zero
    for (genvar i = 0; i < lrft_pkg::SIG_W; i++) begin : g_res
        wire [4:0] need = 5'(lrft_pkg::SIG_W - lrft_pkg::MIN_BITS)
            - 5'(ct_q);
        assign sig_now[i] = (5'(i) >= need) & raw_sig[i];
    end

    // linear code and expanded limits share one lsb weight
    wire [27:0] lin_now = 28'({8'h00, sig_now} << range_q);
    wire [35:0] lin_ext = {8'h00, lin_now};
    wire [35:0] thr_hi_x = 36'({24'h000000, thr_hi_q.significand})
        << (lrft_pkg::THR_PAD + 6'(thr_hi_q.exponent));
    wire [35:0] thr_lo_x = 36'({24'h000000, thr_lo_q.significand})
        << (lrft_pkg::THR_PAD + 6'(thr_lo_q.exponent));
    wire fault_hi = lin_ext > thr_hi_x;
    wire fault_lo = lin_ext < thr_lo_x;

    // persistence: code n needs 2**n consecutive faults
    wire [3:0] fc_need = 4'(1) << fc_q;
    wire [3:0] hi_next = fault_hi ? hi_cnt_q + 4'h1 : 4'h0;
    wire [3:0] lo_next = fault_lo ? lo_cnt_q + 4'h1 : 4'h0;
    wire hi_qual = hi_next >= fc_need;
    wire lo_qual = lo_next >= fc_need;

    // conversion end and its outcome
    wire conv_end = (st_q == lrft_pkg::LRFT_CONV) && (cnt_q == 32'h1);
    wire retry = auto_rng & adc_ovf & (range_q < lrft_pkg::RG_MAX);
    wire report = conv_end & ~retry;
    wire want_start = (md_q == lrft_pkg::MD_CONT)
        | (md_q == lrft_pkg::MD_ONESHOT);
    wire begin_conv = (st_q == lrft_pkg::LRFT_IDLE) & want_start;
    wire oneshot_done = report & (md_q == lrft_pkg::MD_ONESHOT);
    wire [3:0] rg_start = auto_rng ? range_q : rg_q;

    // auto range steering for the following measurement
    wire go_up = auto_rng & (sig_now >= lrft_pkg::SIG_HIGH_SIDE)
        & (range_q < lrft_pkg::RG_MAX);
    wire go_dn = auto_rng & (sig_now < lrft_pkg::SIG_LOW_SIDE)
        & (range_q != 4'h0);

    // events
    wire ev_hi = report & hi_qual & ~flag_hi_q;
    wire ev_lo = report & lo_qual & ~flag_lo_q;
    wire [2:0] ev = {ev_lo, ev_hi, report};

    // read mux
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        if (a_ctrl) begin
            rd_val[lrft_pkg::CT_LSB +: 4] = ct_q;
            rd_val[lrft_pkg::RG_LSB +: 4] = rg_q;
            rd_val[lrft_pkg::FC_LSB +: 2] = fc_q;
            rd_val[lrft_pkg::MD_LSB +: 2] = md_q;
        end
        if (a_thi) rd_val[15:0] = thr_hi_q;
        if (a_tlo) rd_val[15:0] = thr_lo_q;
        // upper field: exponent over top 12 significand bits
        if (a_rup) rd_val[15:0] = {res_q.exponent,
            res_q.result_significand[19:8]};
        if (a_rlo) rd_val[7:0] = res_q.result_significand[7:0];
        if (a_lin) rd_val[27:0] = lin_q;
        if (a_ist) rd_val[2:0] = stat_q;
        if (a_msk) rd_val[2:0] = mask_q;
        if (a_sts) rd_val[7:0] = {range_q, st_q == lrft_pkg::LRFT_CONV,
            1'b0, flag_lo_q, flag_hi_q};
    end

    // sticky status: a read clears only the bits it returned, so an event
    // landing between setup and access survives; a same-cycle event wins
    wire [2:0] stat_clr = (rd_en & a_ist) ? prdata_q[2:0] : 3'h0;
    assign stat_d = (stat_q & ~stat_clr) | ev;

    // apb answer: no wait state, data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            prdata_q <= setup ? rd_val : 32'h0;
            pslverr_q <= setup & ~a_hit;
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ct_q <= lrft_pkg::CT_RST;
            rg_q <= lrft_pkg::RG_RST;
            fc_q <= lrft_pkg::FC_RST;
            md_q <= lrft_pkg::MD_STANDBY;
            thr_hi_q <= '0;
            thr_lo_q <= '0;
            mask_q <= 3'h0;
            stat_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
            if (wr_en & a_ctrl) begin
                if (ct_ok) ct_q <= w_ct;
                if (rg_ok) rg_q <= w_rg;
                fc_q <= pwdata[lrft_pkg::FC_LSB +: 2];
                md_q <= pwdata[lrft_pkg::MD_LSB +: 2];
            end else if (oneshot_done) begin
                md_q <= lrft_pkg::MD_STANDBY;
            end
            if (wr_en & a_thi) thr_hi_q <= pwdata[15:0];
            if (wr_en & a_tlo) thr_lo_q <= pwdata[15:0];
            if (wr_en & a_msk) mask_q <= pwdata[lrft_pkg::IRQ_W-1:0];
        end
    end

    // measurement sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= lrft_pkg::LRFT_IDLE;
            cnt_q <= 32'h0;
            range_q <= 4'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (st_q)
                lrft_pkg::LRFT_IDLE: begin
                    if (begin_conv) begin
                        st_q <= lrft_pkg::LRFT_CONV;
                        cnt_q <= conv_cyc;
                        range_q <= rg_start;
                        start_q <= 1'b1;
                    end
                end
                lrft_pkg::LRFT_CONV: begin
                    if (!conv_end) begin
                        cnt_q <= cnt_q - 32'h1;
                    end else if (retry) begin
                        cnt_q <= conv_cyc;
                        range_q <= range_q + 4'h1;
                        start_q <= 1'b1;
                    end else begin
                        st_q <= lrft_pkg::LRFT_IDLE;
                        if (go_up) range_q <= range_q + 4'h1;
                        else if (go_dn) range_q <= range_q - 4'h1;
                    end
                end
                default: st_q <= lrft_pkg::LRFT_IDLE;
            endcase
        end
    end

    // result capture and limit flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_q <= '0;
            lin_q <= 28'h0;
            hi_cnt_q <= 4'h0;
            lo_cnt_q <= 4'h0;
            flag_hi_q <= 1'b0;
            flag_lo_q <= 1'b0;
        end else if (report) begin
            res_q <= {range_q, sig_now};
            lin_q <= lin_now;
            hi_cnt_q <= hi_qual ? fc_need : hi_next;
            lo_cnt_q <= lo_qual ? fc_need : lo_next;
            if (hi_qual) begin
                flag_hi_q <= 1'b1;
                flag_lo_q <= 1'b0;
            end else if (lo_qual) begin
                flag_lo_q <= 1'b1;
                flag_hi_q <= 1'b0;
            end
        end
    end

    // outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign afe_start = start_q;
    assign afe_range = range_q;
    assign irq = irq_q;
endmodule // lrft_top

// ### lrft_top_tb.sv
`timescale 1ns/1ps
module lrft_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic pready, pslverr, adc_ovf, afe_start, irq, err;
    logic [19:0] adc_code, light = 20'h0;
    logic [3:0] afe_range, sat_range = 4'h0;
    int starts_q, bad_count = 0, samples_checked = 0, i, n;

    always #2.5 pclk = ~pclk;

    lrft_top #(.CYC_PER_US(1)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_code(adc_code), .adc_ovf(adc_ovf),
        .afe_start(afe_start), .afe_range(afe_range), .irq(irq));
    lrft_afe_model u_afe (.pclk(pclk), .presetn(presetn),
        .afe_start(afe_start), .afe_range(afe_range), .light(light),
        .sat_range(sat_range), .adc_code(adc_code), .adc_ovf(adc_ovf),
        .starts_q(starts_q));

    task report_and_stop;
        $display("checks %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task tmo;
        bad_count++;
        $display("BAD %0t wait ran out", $time);
        report_and_stop();
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rq = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) tmo();
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rq, exp);
    endtask
    // one-shot start, wait on the done interrupt, read status to clear it
    task conv(input logic [31:0] ctl);
        apb(1'b1, lrft_pkg::OFS_CTRL, ctl);
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) tmo();
        apb(1'b0, lrft_pkg::OFS_IRQ_STAT, 32'h0);
    endtask

    task t_regs;
        rd_chk(lrft_pkg::OFS_CTRL, 32'h0000_00C8);
        rd_chk(8'h24, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, lrft_pkg::OFS_CTRL, 32'h0000_0090);
        rd_chk(lrft_pkg::OFS_CTRL, 32'h0000_00C0);
        apb(1'b1, lrft_pkg::OFS_IRQ_MASK, 32'h7);
        rd_chk(lrft_pkg::OFS_IRQ_MASK, 32'h7);
    endtask
    task t_auto;
        light <= 20'h20000;
        sat_range <= 4'h1;
        conv(32'h0000_10C0);
        chk(rq & 32'h1, 32'h1);
        chk(32'(starts_q), 32'h2);
        rd_chk(lrft_pkg::OFS_RES_UP, 32'h1200);
    endtask
    task t_manual;
        light <= 20'hABCDE;
        sat_range <= 4'h0;
        conv(32'h0000_1030);
        chk({28'h0, afe_range}, 32'h3);
        rd_chk(lrft_pkg::OFS_RES_UP, 32'h3AB8);
        rd_chk(lrft_pkg::OFS_RES_LO, 32'h0);
        rd_chk(lrft_pkg::OFS_LINEAR, 32'h0055_C000);
    endtask
    task t_limits;
        apb(1'b1, lrft_pkg::OFS_THR_HI, 32'hFFFF);
        apb(1'b1, lrft_pkg::OFS_THR_LO, 32'h455D);
        conv(32'h0000_1030);
        rd_chk(lrft_pkg::OFS_STATUS, 32'h32);
        // limits equal to the linear code: no fault either way
        apb(1'b1, lrft_pkg::OFS_THR_HI, 32'h455C);
        apb(1'b1, lrft_pkg::OFS_THR_LO, 32'h455C);
        conv(32'h0000_1030);
        rd_chk(lrft_pkg::OFS_STATUS, 32'h32);
        apb(1'b1, lrft_pkg::OFS_THR_HI, 32'h455B);
        for (i = 1; i <= 4; i++) begin
            conv(32'h0000_1230);
            chk(rq & 32'h2, (i == 4) ? 32'h2 : 32'h0);
            rd_chk(lrft_pkg::OFS_STATUS, (i == 4) ? 32'h31 : 32'h32);
        end
    endtask
    task t_mask;
        apb(1'b1, lrft_pkg::OFS_IRQ_MASK, 32'h0);
        apb(1'b1, lrft_pkg::OFS_CTRL, 32'h0000_1030);
        i = 0;
        repeat (700) begin
            @(posedge pclk);
            if (irq !== 1'b0) i++;
        end
        chk(32'(i), 32'h0);
        rd_chk(lrft_pkg::OFS_IRQ_STAT, 32'h1);
        rd_chk(lrft_pkg::OFS_IRQ_STAT, 32'h0);
    endtask
    // continuous mode: starts are one period plus one idle cycle apart
    task t_cont;
        light <= 20'hFFFFF;
        apb(1'b1, lrft_pkg::OFS_CTRL, 32'h0000_2081);
        n = 0;
        while (afe_start !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) tmo();
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (afe_start !== 1'b1 && i < 3000);
        chk(32'(i), 32'(lrft_pkg::CONV_US[1]) + 32'h1);
        rd_chk(lrft_pkg::OFS_RES_UP, 32'h8FFC);
        rd_chk(lrft_pkg::OFS_RES_LO, 32'h0);
        rd_chk(lrft_pkg::OFS_LINEAR, 32'h0FFC_0000);
        // back to standby: the running conversion still completes
        apb(1'b1, lrft_pkg::OFS_CTRL, 32'h0000_0081);
        repeat (1100) @(posedge pclk);
        rd_chk(lrft_pkg::OFS_STATUS, 32'h81);
        chk(32'(starts_q), 32'hC);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_auto();
        t_manual();
        t_limits();
        t_mask();
        t_cont();
        report_and_stop();
    end
endmodule // lrft_top_tb
